// *** rtl/sts_regs.svh ***
`ifndef STS_REGS_SVH
`define STS_REGS_SVH

// Register byte offsets
`define STS_OFS_FLAGS 8'h00
`define STS_OFS_FLAG_CLR 8'h04
`define STS_OFS_SEM 8'h08
`define STS_OFS_SEM_A 8'h0C
`define STS_OFS_SEM_B 8'h10
`define STS_OFS_START_A 8'h14
`define STS_OFS_START_B 8'h18
`define STS_OFS_IRQ_STAT 8'h1C
`define STS_OFS_IRQ_MASK 8'h20

// Event flag positions
`define STS_FLG_NMI 0
`define STS_FLG_CLK 1
`define STS_FLG_RAM 2
`define STS_FLG_FLASH 3
`define STS_FLG_ST_A 4
`define STS_FLG_ST_B 5
`define STS_FLG_W 6
`define STS_FLG_RESET 6'h00

// Owner semaphore codes
`define STS_SEM_RESET 2'h0
`define STS_SEM_B_OWNS 2'h1
`define STS_SEM_A_OWNS 2'h2
`define STS_SEM_FREE 2'h3

// Interrupt status positions
`define STS_IRQ_NMI 0
`define STS_IRQ_SEM 1
`define STS_IRQ_REFUSE 2
`define STS_IRQ_W 3
`define STS_IRQ_RESET 3'h0

`define STS_START_BIT 0
`define STS_RESP_OKAY 2'h0
`define STS_RESP_SLVERR 2'h2

`endif

// *** rtl/sts_pkg.sv ***
package sts_pkg;
    typedef logic [1:0] sts_sem_t;
    typedef logic [5:0] sts_flags_t;
    typedef logic [2:0] sts_irq_t;
    typedef logic [31:0] sts_word_t;
endpackage

// *** rtl/sts_axil_slave.sv ***
`timescale 1ns/100ps
module sts_axil_slave #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    `include "sts_regs.svh"

    // A low ready means that channel holds a taken item
    assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_en = !s_axi_arready && !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `STS_RESP_OKAY;
            wr_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_en) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? `STS_RESP_SLVERR : `STS_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `STS_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            rd_addr <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                rd_addr <= s_axi_araddr;
            end
            if (rd_en) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_err ? `STS_RESP_SLVERR : `STS_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// *** rtl/sts_top.sv ***
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module sts_top #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic flash_unc_err,
    input wire logic ram_unc_err,
    input wire logic clock_fail,
    input wire logic st_timeout,
    input wire logic st_sig_mismatch,
    output logic nmi_pulse,
    output logic selftest_grant_a,
    output logic selftest_grant_b,
    output logic selftest_start_a,
    output logic selftest_start_b,
    output logic irq
);
    `include "sts_regs.svh"

    generate
        if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
            $error("sts_top: ADDR_W must lie between 6 and 32");
        end
    endgenerate

    function automatic logic may_change(input sts_pkg::sts_sem_t s, input logic core_b);
        may_change = core_b ? (s != `STS_SEM_A_OWNS) : (s != `STS_SEM_B_OWNS);
    endfunction

    // Free code grants nobody, so a stale owner cannot keep running
    function automatic logic has_res(input sts_pkg::sts_sem_t s, input logic core_b);
        has_res = core_b ? (s == `STS_SEM_B_OWNS)
                         : (s == `STS_SEM_RESET || s == `STS_SEM_A_OWNS);
    endfunction

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_err;
    logic rd_err;

    sts_axil_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    sts_pkg::sts_flags_t flags;
    sts_pkg::sts_flags_t next_flags;
    sts_pkg::sts_sem_t sem;
    sts_pkg::sts_sem_t next_sem;
    sts_pkg::sts_irq_t irq_stat;
    sts_pkg::sts_irq_t next_irq_stat;
    sts_pkg::sts_irq_t irq_mask;
    logic run_core_b;

    // Address decode
    wire [7:0] wa = 8'(wr_addr);
    wire [7:0] ra = 8'(rd_addr);
    wire wr_high_zero = (wr_addr >> 8) == '0;
    wire rd_high_zero = (rd_addr >> 8) == '0;
    wire wr_byte0 = wr_en && wr_strb[0] && wr_high_zero;
    wire wr_clr = wr_byte0 && wa == `STS_OFS_FLAG_CLR;
    wire wr_sem_a = wr_byte0 && wa == `STS_OFS_SEM_A;
    wire wr_sem_b = wr_byte0 && wa == `STS_OFS_SEM_B;
    wire wr_go_a = wr_byte0 && wa == `STS_OFS_START_A && wr_data[`STS_START_BIT];
    wire wr_go_b = wr_byte0 && wa == `STS_OFS_START_B && wr_data[`STS_START_BIT];
    wire wr_mask = wr_byte0 && wa == `STS_OFS_IRQ_MASK;
    wire rd_stat = rd_en && rd_high_zero && ra == `STS_OFS_IRQ_STAT;
    wire [1:0] wr_val = wr_data[1:0];

    wire wr_known = wa == `STS_OFS_FLAGS || wa == `STS_OFS_FLAG_CLR || wa == `STS_OFS_SEM
        || wa == `STS_OFS_SEM_A || wa == `STS_OFS_SEM_B || wa == `STS_OFS_START_A
        || wa == `STS_OFS_START_B || wa == `STS_OFS_IRQ_STAT || wa == `STS_OFS_IRQ_MASK;
    assign wr_err = !(wr_known && wr_high_zero);

    // Ownership checks
    wire ok_sem_a = may_change(sem, 1'b0);
    wire ok_sem_b = may_change(sem, 1'b1);
    wire res_a = has_res(sem, 1'b0);
    wire res_b = has_res(sem, 1'b1);
    wire take_sem_a = wr_sem_a && ok_sem_a;
    wire take_sem_b = wr_sem_b && ok_sem_b;
    wire go_a = wr_go_a && res_a;
    wire go_b = wr_go_b && res_b;
    wire refused = (wr_sem_a && !ok_sem_a) || (wr_sem_b && !ok_sem_b)
        || (wr_go_a && !res_a) || (wr_go_b && !res_b);

    assign next_sem = take_sem_a ? wr_val : (take_sem_b ? wr_val : sem);
    wire sem_changed = next_sem != sem;

    // Event flags; a set in the clearing cycle wins
    wire st_err = st_timeout || st_sig_mismatch;
    wire [5:1] ev_set = {st_err && run_core_b, st_err && !run_core_b, flash_unc_err,
        ram_unc_err, clock_fail};
    wire [5:1] pend = flags[5:1] | ev_set;
    wire nmi_fire = !flags[`STS_FLG_NMI] && (|pend);
    wire [5:0] clr_vec = wr_clr ? wr_data[5:0] : 6'h00;
    assign next_flags = (flags & ~clr_vec) | {ev_set, nmi_fire};

    // Status clears on read, events in that cycle survive
    wire [2:0] irq_ev = {refused, sem_changed, nmi_fire};
    assign next_irq_stat = (rd_stat ? 3'h0 : irq_stat) | irq_ev;

    // Read mux
    wire rd_known = ra == `STS_OFS_FLAGS || ra == `STS_OFS_FLAG_CLR || ra == `STS_OFS_SEM
        || ra == `STS_OFS_SEM_A || ra == `STS_OFS_SEM_B || ra == `STS_OFS_START_A
        || ra == `STS_OFS_START_B || ra == `STS_OFS_IRQ_STAT || ra == `STS_OFS_IRQ_MASK;
    assign rd_err = !(rd_known && rd_high_zero);
    wire [31:0] rd_flags = {26'h0, flags};
    wire [31:0] rd_sem = {30'h0, sem};
    wire [31:0] rd_stat_w = {29'h0, irq_stat};
    wire [31:0] rd_mask_w = {29'h0, irq_mask};
    assign rd_data = (ra == `STS_OFS_FLAGS) ? rd_flags
        : (ra == `STS_OFS_SEM) ? rd_sem
        : (ra == `STS_OFS_IRQ_STAT) ? rd_stat_w
        : (ra == `STS_OFS_IRQ_MASK) ? rd_mask_w
        : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= `STS_FLG_RESET;
            nmi_pulse <= 1'b0;
        end else begin
            flags <= next_flags;
            nmi_pulse <= nmi_fire;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sem <= `STS_SEM_RESET;
            selftest_grant_a <= 1'b1;
            selftest_grant_b <= 1'b0;
            selftest_start_a <= 1'b0;
            selftest_start_b <= 1'b0;
            run_core_b <= 1'b0;
        end else begin
            sem <= next_sem;
            selftest_grant_a <= has_res(next_sem, 1'b0);
            selftest_grant_b <= has_res(next_sem, 1'b1);
            selftest_start_a <= go_a;
            selftest_start_b <= go_b;
            if (go_a || go_b) begin
                run_core_b <= go_b;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= `STS_IRQ_RESET;
            irq_mask <= `STS_IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_mask) begin
                irq_mask <= wr_data[2:0];
            end
            irq <= |(next_irq_stat & (wr_mask ? wr_data[2:0] : irq_mask));
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Summary bit may be cleared in the same cycle while already set, so exclude that case
    flash_latch_a: assert property (flash_unc_err && !clr_vec[0]
        |=> flags[`STS_FLG_FLASH] && flags[0])
        else $error("flash error not latched");
    ram_latch_a: assert property (ram_unc_err |=> ##[0:2] flags[`STS_FLG_RAM])
        else $error("ram error not latched");
    clock_latch_a: assert property (clock_fail && !wr_clr |=> flags[`STS_FLG_CLK])
        else $error("clock fail not latched");
    nmi_flag_a: assert property (nmi_pulse |-> flags[`STS_FLG_NMI] && !$past(flags[0]))
        else $error("nmi pulse without fresh summary flag");
    nmi_quiet_a: assert property (flags[`STS_FLG_NMI] && !wr_clr |=> !nmi_pulse[*2])
        else $error("nmi pulse while summary flag set");
    flag_hold_a: assert property ($fell(flags[`STS_FLG_FLASH]) |-> $past(clr_vec[3]))
        else $error("flag dropped without clear");
    one_owner_a: assert property (!(selftest_grant_a && selftest_grant_b))
        else $error("both cores granted");
    start_gate_a: assert property (selftest_start_b |-> $past(sem) == `STS_SEM_B_OWNS)
        else $error("core b started without ownership");
    reset_sem_a: assert property ($rose(aresetn) |-> sem == `STS_SEM_RESET && selftest_grant_a)
        else $error("semaphore not zero after reset");
    lock_b_a: assert property (sem == `STS_SEM_A_OWNS && wr_sem_b
        |=> sem == `STS_SEM_A_OWNS && irq_stat[`STS_IRQ_REFUSE])
        else $error("core b changed semaphore held by a");
    lock_a_a: assert property (sem == `STS_SEM_B_OWNS && wr_sem_a
        |=> sem == `STS_SEM_B_OWNS && !selftest_grant_a)
        else $error("core a changed semaphore held by b");
    free_take_a: assert property (sem == `STS_SEM_FREE && (wr_sem_a || wr_sem_b)
        |=> sem == $past(wr_val))
        else $error("free semaphore not taken");
    st_err_a: assert property (st_timeout && run_core_b |=> flags[`STS_FLG_ST_B])
        else $error("core b self-test error not flagged");

    nmi_seen_c: cover property (nmi_pulse);
    own_a_c: cover property (sem == `STS_SEM_A_OWNS ##[1:50] sem == `STS_SEM_FREE);
    own_b_c: cover property (sem == `STS_SEM_B_OWNS && selftest_start_b);
    irq_seen_c: cover property (irq && rd_stat);
endmodule

// *** bench/sts_core_model.sv ***
`timescale 1ns/100ps
module sts_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start_a,
    input wire logic start_b,
    input wire logic [1:0] fail_kind,
    output logic st_timeout,
    output logic st_sig_mismatch
);
    // Fixed run length keeps expectations simple; real runs vary
    logic run;
    logic [2:0] cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            cnt <= 3'h0;
            st_timeout <= 1'b0;
            st_sig_mismatch <= 1'b0;
        end else begin
            st_timeout <= 1'b0;
            st_sig_mismatch <= 1'b0;
            if (start_a || start_b) begin
                run <= 1'b1;
                cnt <= 3'h0;
            end else if (run) begin
                cnt <= cnt + 3'h1;
                if (cnt == 3'h3) begin
                    run <= 1'b0;
                    st_timeout <= (fail_kind == 2'h1);
                    st_sig_mismatch <= (fail_kind == 2'h2);
                end
            end
        end
    end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
`include "sts_regs.svh"
module tb;
    typedef struct packed {logic [7:0] addr; logic [1:0] val; logic [1:0] sem;} sts_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [1:0] fk = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, nmi, ga, gb, sa, sb, irq, sto, smm;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rv;
    int n_mismatch = 0;
    int check_count = 0;
    int n_nmi = 0;
    int n_sa = 0;
    int n_sb = 0;
    sts_row_s rows [9] = '{'{`STS_OFS_SEM_A, 2'h2, 2'h2}, '{`STS_OFS_SEM_B, 2'h1, 2'h2},
        '{`STS_OFS_SEM_A, 2'h3, 2'h3}, '{`STS_OFS_SEM_B, 2'h1, 2'h1},
        '{`STS_OFS_SEM_A, 2'h2, 2'h1}, '{`STS_OFS_SEM_B, 2'h3, 2'h3},
        '{`STS_OFS_SEM_A, 2'h0, 2'h0}, '{`STS_OFS_SEM_B, 2'h1, 2'h1},
        '{`STS_OFS_SEM_B, 2'h3, 2'h3}};

    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (nmi) n_nmi++;
        if (sa) n_sa++;
        if (sb) n_sb++;
    end

    sts_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .flash_unc_err(ev[0]), .ram_unc_err(ev[1]),
        .clock_fail(ev[2]), .st_timeout(sto), .st_sig_mismatch(smm), .nmi_pulse(nmi),
        .selftest_grant_a(ga), .selftest_grant_b(gb), .selftest_start_a(sa),
        .selftest_start_b(sb), .irq(irq));
    sts_core_model partner (.aclk(aclk), .aresetn(aresetn), .start_a(sa), .start_b(sb),
        .fail_kind(fk), .st_timeout(sto), .st_sig_mismatch(smm));

    task print_verdict;
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (i == 40) chk("write handshake", 32'h1, 32'h0);
        if (i == 40) print_verdict;
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (i == 40) chk("read handshake", 32'h1, 32'h0);
        if (i == 40) print_verdict;
    endtask
    task pulse(input logic [2:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'h0, rv);
        rd(`STS_OFS_SEM);
        chk("sem", 32'h0, rv);
        chk("grants", 32'h1, 32'({gb, ga}));
        rd(8'h24);
        chk("unmapped rresp", 32'h2, 32'(resp));
        wr(8'h24, 32'h3);
        chk("unmapped bresp", 32'h2, 32'(resp));
        foreach (rows[k]) begin
            wr(rows[k].addr, 32'(rows[k].val));
            rd(`STS_OFS_SEM);
            chk("sem", 32'(rows[k].sem), rv);
            chk("grants", 32'({rows[k].sem == 2'h1, rows[k].sem[0] == 1'b0}), 32'({gb, ga}));
        end
        rd(`STS_OFS_IRQ_STAT);
        chk("irq status", 32'h6, rv);
        chk("irq masked", 32'h0, 32'(irq));
        wr(`STS_OFS_IRQ_MASK, 32'h7);
        pulse(3'h1);
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'h9, rv);
        chk("irq", 32'h1, 32'(irq));
        pulse(3'h2);
        pulse(3'h4);
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'hF, rv);
        chk("nmi count", 32'h1, 32'(n_nmi));
        wr(`STS_OFS_FLAGS, 32'h0);
        wr(`STS_OFS_FLAG_CLR, 32'h1);
        repeat (3) @(posedge aclk);
        chk("nmi count", 32'h2, 32'(n_nmi));
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'hF, rv);
        wr(`STS_OFS_FLAG_CLR, 32'hE);
        wr(`STS_OFS_FLAG_CLR, 32'h1);
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'h0, rv);
        rd(`STS_OFS_IRQ_STAT);
        chk("irq status", 32'h1, rv);
        chk("irq cleared", 32'h0, 32'(irq));
        // Free semaphore: nobody may start
        wr(`STS_OFS_START_A, 32'h1);
        fk <= 2'h1;
        wr(`STS_OFS_SEM_A, 32'h2);
        wr(`STS_OFS_START_A, 32'h1);
        wr(`STS_OFS_START_B, 32'h1);
        repeat (10) @(posedge aclk);
        chk("starts", 32'h1, 32'({n_sb[7:0], n_sa[7:0]}));
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'h11, rv);
        wr(`STS_OFS_SEM_A, 32'h3);
        wr(`STS_OFS_FLAG_CLR, 32'h11);
        fk <= 2'h2;
        wr(`STS_OFS_SEM_B, 32'h1);
        wr(`STS_OFS_START_B, 32'h1);
        repeat (10) @(posedge aclk);
        chk("starts", 32'h101, 32'({n_sb[7:0], n_sa[7:0]}));
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'h21, rv);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`STS_OFS_FLAGS);
        chk("flags", 32'h0, rv);
        rd(`STS_OFS_SEM);
        chk("sem", 32'h0, rv);
        print_verdict;
    end
endmodule
